/* File: common/tlv_consts.vh */
`ifndef TLV_CONSTS_VH
`define TLV_CONSTS_VH

// Machine cycle shape, in system clocks
`define TLV_MC_CLKS      3'h4
`define TLV_PH_SAMPLE    2'h2
`define TLV_PH_POLL      2'h3
// Hardware call length, in machine cycles
`define TLV_CALL_MCS     3'h4

// Register word indexes (byte address bits 7:2)
`define TLV_OFS_CTRL     6'h00
`define TLV_OFS_MASK     6'h01
`define TLV_OFS_PRIO     6'h02
`define TLV_OFS_FLAG     6'h03
`define TLV_OFS_STAT     6'h04

// Control register fields
`define TLV_CTRL_GATE    0
`define TLV_CTRL_EDGE0   1
`define TLV_CTRL_EDGE1   2

// Source index order, highest first
`define TLV_SRC_EXT0     0
`define TLV_SRC_TMR0     1
`define TLV_SRC_EXT1     2
`define TLV_SRC_TMR1     3
`define TLV_SRC_UART     4
`define TLV_SRC_CONV     5
`define TLV_SRC_EXT2     6
`define TLV_SRC_EXT3     7
`define TLV_SRC_WDOG     8
`define TLV_SRC_PWM      9
// Extra flag bit: uart transmit done
`define TLV_FLG_UTX      10

// Vector addresses
`define TLV_VEC_EXT0     16'h0003
`define TLV_VEC_TMR0     16'h000B
`define TLV_VEC_EXT1     16'h0013
`define TLV_VEC_TMR1     16'h001B
`define TLV_VEC_UART     16'h0023
`define TLV_VEC_CONV     16'h003B
`define TLV_VEC_EXT2     16'h0043
`define TLV_VEC_EXT3     16'h004B
`define TLV_VEC_WDOG     16'h0063
`define TLV_VEC_PWM      16'h006B

// Reset values
`define TLV_RST_CTRL     3'h0
`define TLV_RST_MASK     10'h000
`define TLV_RST_PRIO     10'h000
`define TLV_RST_FLAG     11'h000

`endif

/* File: verilog/tlv_pin_samp.v */
`timescale 1ns/1ps
`default_nettype none

// Samples one interrupt pin once per machine cycle and flags transitions
module tlv_pin_samp #(
	parameter IDLE_LVL = 1'b1          // Level assumed before first sample
) (
	input  wire hclk,                  // System clock
	input  wire hresetn,               // Async reset, active low
	input  wire smp,                   // Sample strobe, once per mc
	input  wire pin,                   // Pin level
	output reg  level,                 // Last sampled level
	output reg  rise,                  // Low then high, one clock
	output reg  fall                   // High then low, one clock
);

	// Compare this sample with the previous one
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level <= IDLE_LVL;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else if (smp) begin
			level <= pin;
			rise  <= pin & ~level;
			fall  <= ~pin & level;
		end else begin
			rise  <= 1'b0;
			fall  <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* File: verilog/tlv_irq_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "tlv_consts.vh"

// How it works
// - Ten sources, two levels, one global gate
// - Ext 0/1 edge or level by select
// - Ext 2 rising only, ext 3 falling only
// - Pins sampled once per machine cycle
// - Level mode: no clear on handler entry
// - Edge mode: ext 0/1 cleared on vectoring
// - Ext 2/3 flags cleared by software only
// - Timer flags cleared on vectoring
// - Watchdog flag set always, software clears
// - Uart rx and tx share one source
// - Pwm rising edge sets flag when enabled
// - Conversion end sets irq and idle flags
// - Software can write every flag
// - Per-source enables plus global gate
// - Fixed order and vectors within a level
// - High level never preempted by low
// - Call only when three conditions hold
// - Blocked requests are not remembered
// - Call pushes pc, not status word
// - Only handler exit ends in-service state
// - Select 0 level (reset), 1 edge
// - Level mode flag is inverse of pin
// - Call lasts four machine cycles
module tlv_irq_ctrl (
	input  wire        hclk,           // System clock
	input  wire        hresetn,        // Async reset, active low
	input  wire        hsel,           // Slave select
	input  wire [31:0] haddr,          // Byte address
	input  wire [1:0]  htrans,         // Transfer type
	input  wire        hwrite,         // Write when high
	input  wire [2:0]  hsize,          // Transfer size
	input  wire [31:0] hwdata,         // Write data
	input  wire        hready,         // Bus ready
	output reg  [31:0] hrdata,         // Read data
	output reg         hreadyout,      // Slave ready
	output reg         hresp,          // Always OKAY
	input  wire        ext_irq0_n,     // External request 0, low
	input  wire        ext_irq1_n,     // External request 1, low
	input  wire        ext_irq2_rise,  // External request 2
	input  wire        ext_irq3_n,     // External request 3, low
	input  wire        timer0_ovf,     // Timer 0 overflow pulse
	input  wire        timer1_ovf,     // Timer 1 overflow pulse
	input  wire        uart_rx_done,   // Uart receive done pulse
	input  wire        uart_tx_done,   // Uart transmit done pulse
	input  wire        conv_done,      // Conversion end pulse
	input  wire        conv_start,     // Conversion start pulse
	input  wire        wdog_timeout,   // Watchdog timeout pulse
	input  wire        pwm_out,        // Pwm output level
	input  wire        instr_last,     // Last mc of instruction
	input  wire        instr_blocks,   // Ctl-reg write or exit
	input  wire        handler_exit,   // Handler exit executed
	output reg         mc_strobe,      // Poll machine cycle end
	output reg         call_req,       // Start hardware call
	output reg  [15:0] call_vector,    // Target vector address
	output reg         call_save_psw,  // Status word saved: never
	output reg         call_busy,      // Hardware call running
	output reg  [1:0]  in_service,     // {high, low} in service
	output reg         conv_idle       // Converter idle status
);

	//////////////////////////////////////////////////////////////
	// Registers and state

	reg  [2:0]  ctrl;                  // Gate and edge selects
	reg  [9:0]  mask;                  // Per-source enables
	reg  [9:0]  prio;                  // Per-source high level
	reg  [10:0] flags;                 // Request flags
	reg  [1:0]  phase;                 // Machine cycle phase
	reg  [2:0]  call_cnt;              // Call mcs left
	reg         pwm_prev;              // Pwm level last clock
	reg         wr_pend;               // Write data phase due
	reg  [5:0]  wr_idx;                // Write register index

	wire        smp_tick;              // Pin sample clock
	wire        poll_tick;             // Poll clock
	wire [3:0]  pin_raw;               // Pins as requests
	wire [3:0]  pin_lvl;               // Sampled pin levels
	wire [3:0]  pin_rise;              // Sampled rising edges
	wire [3:0]  pin_fall;              // Sampled falling edges
	wire        a_phase;               // Valid address phase
	wire [5:0]  a_idx;                 // Address word index
	wire [9:0]  req;                   // Raised requests
	wire [9:0]  req_hi;                // Eligible high requests
	wire [9:0]  req_lo;                // Eligible low requests
	wire        can_poll;              // Core allows a call

	reg  [10:0] next_flags;            // Flag update
	reg  [31:0] next_rdata;            // Read mux
	reg  [3:0]  win_idx;               // Winning source
	reg         win_hi;                // Winner level
	reg         win_ok;                // Some source wins
	reg  [10:0] hw_clr;                // Clears on vectoring
	reg  [10:0] hw_set;                // Hardware events

	//////////////////////////////////////////////////////////////
	// Vector lookup

	function [15:0] vec_of;
		input [3:0] idx;
		begin
			case (idx)
				4'h0:    vec_of = `TLV_VEC_EXT0;
				4'h1:    vec_of = `TLV_VEC_TMR0;
				4'h2:    vec_of = `TLV_VEC_EXT1;
				4'h3:    vec_of = `TLV_VEC_TMR1;
				4'h4:    vec_of = `TLV_VEC_UART;
				4'h5:    vec_of = `TLV_VEC_CONV;
				4'h6:    vec_of = `TLV_VEC_EXT2;
				4'h7:    vec_of = `TLV_VEC_EXT3;
				4'h8:    vec_of = `TLV_VEC_WDOG;
				default: vec_of = `TLV_VEC_PWM;
			endcase
		end
	endfunction

	//////////////////////////////////////////////////////////////
	// Machine cycle timing

	assign smp_tick  = (phase == `TLV_PH_SAMPLE);
	assign poll_tick = (phase == `TLV_PH_POLL);

	// Phase counter and the strobe shown to the core
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase     <= 2'h0;
			mc_strobe <= 1'b0;
		end else begin
			phase     <= phase + 2'h1;
			mc_strobe <= smp_tick;     // High during poll clock
		end
	end

	//////////////////////////////////////////////////////////////
	// Pin sampling

	// Ext 2 is active high; invert it to share the detector
	assign pin_raw = {ext_irq3_n, ~ext_irq2_rise, ext_irq1_n,
		ext_irq0_n};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
			tlv_pin_samp #(
				.IDLE_LVL (1'b1)
			) u_samp (
				.hclk    (hclk),
				.hresetn (hresetn),
				.smp     (smp_tick),
				.pin     (pin_raw[gi]),
				.level   (pin_lvl[gi]),
				.rise    (pin_rise[gi]),
				.fall    (pin_fall[gi])
			);
		end
	endgenerate

	// Pwm edge seen on the system clock
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_prev <= 1'b0;
		end else begin
			pwm_prev <= pwm_out;
		end
	end

	//////////////////////////////////////////////////////////////
	// Request resolution

	// Uart rx and tx form one source
	assign req = {flags[9:5], flags[4] | flags[`TLV_FLG_UTX],
		flags[3:0]};

	assign req_hi = req & mask & prio &
		{10{ctrl[`TLV_CTRL_GATE]}};
	assign req_lo = req & mask & ~prio &
		{10{ctrl[`TLV_CTRL_GATE]}};

	// Core conditions, checked fresh on each poll
	assign can_poll = poll_tick & instr_last & ~instr_blocks &
		~handler_exit & ~call_busy;

	// Lowest index wins; high level first
	always @* begin : p_resolve
		integer i;
		win_idx = 4'h0;
		win_hi  = 1'b0;
		win_ok  = 1'b0;
		for (i = 9; i >= 0; i = i - 1) begin
			if (req_lo[i]) begin
				win_idx = i[3:0];
			end
		end
		if (|req_lo && !in_service[1] && !in_service[0]) begin
			win_ok = 1'b1;
		end
		for (i = 9; i >= 0; i = i - 1) begin
			if (req_hi[i]) begin
				win_idx = i[3:0];
			end
		end
		if (|req_hi && !in_service[1]) begin
			win_ok = 1'b1;
			win_hi = 1'b1;
		end else if (|req_hi) begin
			win_ok = 1'b0;
		end
		if (!win_ok) begin
			win_idx = 4'h0;
		end
	end

	//////////////////////////////////////////////////////////////
	// Flag updates

	// Hardware set and clear terms
	always @* begin
		hw_set = 11'h000;
		hw_clr = 11'h000;
		hw_set[`TLV_SRC_EXT0] = pin_fall[0] &
			ctrl[`TLV_CTRL_EDGE0];
		hw_set[`TLV_SRC_EXT1] = pin_fall[1] &
			ctrl[`TLV_CTRL_EDGE1];
		hw_set[`TLV_SRC_EXT2] = pin_fall[2];
		hw_set[`TLV_SRC_EXT3] = pin_fall[3];
		hw_set[`TLV_SRC_TMR0] = timer0_ovf;
		hw_set[`TLV_SRC_TMR1] = timer1_ovf;
		hw_set[`TLV_SRC_UART] = uart_rx_done;
		hw_set[`TLV_FLG_UTX]  = uart_tx_done;
		hw_set[`TLV_SRC_CONV] = conv_done;
		hw_set[`TLV_SRC_WDOG] = wdog_timeout;
		hw_set[`TLV_SRC_PWM]  = pwm_out & ~pwm_prev &
			mask[`TLV_SRC_PWM];
		if (can_poll && win_ok) begin
			case (win_idx)
				4'h0: begin
					hw_clr[`TLV_SRC_EXT0] =
						ctrl[`TLV_CTRL_EDGE0];
				end
				4'h1: begin
					hw_clr[`TLV_SRC_TMR0] = 1'b1;
				end
				4'h2: begin
					hw_clr[`TLV_SRC_EXT1] =
						ctrl[`TLV_CTRL_EDGE1];
				end
				4'h3: begin
					hw_clr[`TLV_SRC_TMR1] = 1'b1;
				end
				default: begin
					hw_clr = 11'h000;
				end
			endcase
		end
	end

	// Write, then hardware clear, then set; set wins
	always @* begin
		next_flags = flags;
		if (wr_pend && wr_idx == `TLV_OFS_FLAG) begin
			next_flags = hwdata[10:0];
		end
		next_flags = (next_flags & ~hw_clr) | hw_set;
		if (smp_tick && !ctrl[`TLV_CTRL_EDGE0]) begin
			next_flags[0] = ~ext_irq0_n;
		end
		if (smp_tick && !ctrl[`TLV_CTRL_EDGE1]) begin
			next_flags[2] = ~ext_irq1_n;
		end
	end

	// Flag register
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags <= `TLV_RST_FLAG;
		end else begin
			flags <= next_flags;
		end
	end

	//////////////////////////////////////////////////////////////
	// Hardware call sequencing

	// Issue, run four machine cycles, track levels
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			call_req      <= 1'b0;
			call_vector   <= 16'h0000;
			call_save_psw <= 1'b0;
			call_busy     <= 1'b0;
			call_cnt      <= 3'h0;
			in_service    <= 2'h0;
		end else begin
			call_req      <= 1'b0;
			call_save_psw <= 1'b0;
			if (can_poll && win_ok) begin
				call_req    <= 1'b1;
				call_vector <= vec_of(win_idx);
				call_busy   <= 1'b1;
				call_cnt    <= `TLV_CALL_MCS;
				if (win_hi) begin
					in_service[1] <= 1'b1;
				end else begin
					in_service[0] <= 1'b1;
				end
			end else begin
				if (poll_tick && call_cnt != 3'h0) begin
					call_cnt <= call_cnt - 3'h1;
					if (call_cnt == 3'h1) begin
						call_busy <= 1'b0;
					end
				end
				if (handler_exit) begin
					if (in_service[1]) begin
						in_service[1] <= 1'b0;
					end else begin
						in_service[0] <= 1'b0;
					end
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////
	// Converter idle status

	// Set at conversion end, cleared when one starts
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_idle <= 1'b1;
		end else if (conv_done) begin
			conv_idle <= 1'b1;
		end else if (conv_start) begin
			conv_idle <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////
	// Bus slave

	assign a_phase = hsel & hready & htrans[1];
	assign a_idx   = haddr[7:2];

	// Read mux, unmapped words read zero
	always @* begin
		next_rdata = 32'h0000_0000;
		case (a_idx)
			`TLV_OFS_CTRL: next_rdata[2:0]  = ctrl;
			`TLV_OFS_MASK: next_rdata[9:0]  = mask;
			`TLV_OFS_PRIO: next_rdata[9:0]  = prio;
			`TLV_OFS_FLAG: next_rdata[10:0] = flags;
			`TLV_OFS_STAT: begin
				next_rdata[1:0]  = in_service;
				next_rdata[2]    = call_busy;
				next_rdata[3]    = conv_idle;
				next_rdata[7:4]  = pin_lvl;
				next_rdata[31:16] = {16{1'b0}};
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Zero-wait slave; writes land at the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= 1'b0;
			wr_idx    <= 6'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= a_phase & hwrite & (hsize == 3'h2);
			wr_idx    <= a_idx;
			if (a_phase && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end

	// Control registers written by software
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `TLV_RST_CTRL;
			mask <= `TLV_RST_MASK;
			prio <= `TLV_RST_PRIO;
		end else if (wr_pend) begin
			case (wr_idx)
				`TLV_OFS_CTRL: ctrl <= hwdata[2:0];
				`TLV_OFS_MASK: mask <= hwdata[9:0];
				`TLV_OFS_PRIO: prio <= hwdata[9:0];
				default:       ctrl <= ctrl;
			endcase
		end
	end

endmodule

`default_nettype wire

/* File: testbench/tlv_irq_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Watches the hardware call handshake at the ports
module tlv_irq_chk (
	input wire logic        hclk,          // Clock
	input wire logic        hresetn,       // Reset, low
	input wire logic        instr_last,    // Last mc
	input wire logic        instr_blocks,  // Blocking op
	input wire logic        handler_exit,  // Exit pulse
	input wire logic        mc_strobe,     // Poll clock
	input wire logic        call_req,      // Call start
	input wire logic [15:0] call_vector,   // Vector
	input wire logic        call_save_psw, // Status save
	input wire logic        call_busy,     // Call runs
	input wire logic [1:0]  in_service     // Levels
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Poll clock that may start a call
	sequence s_poll_ok;
		$past(mc_strobe) && $past(instr_last) &&
		!$past(instr_blocks) && !$past(handler_exit);
	endsequence
	// Call runs exactly four machine cycles
	sequence s_busy16;
		call_busy[*8] ##1 call_busy[*8] ##1 !call_busy;
	endsequence
	a_call_when_ok: assert property (call_req |-> s_poll_ok)
		else $error("call outside an allowed poll");
	a_call_length: assert property (call_req |-> s_busy16)
		else $error("call length wrong");
	a_busy_blocks: assert property (call_busy |=> !call_req)
		else $error("call during running call");
	a_vector_known: assert property (call_req |->
		call_vector inside {16'h0003, 16'h000B, 16'h0013,
		16'h001B, 16'h0023, 16'h003B, 16'h0043, 16'h004B,
		16'h0063, 16'h006B})
		else $error("unknown vector");
	a_level_marked: assert property (call_req |->
		(in_service & ~$past(in_service)) != 2'h0)
		else $error("call set no level");
	a_high_kept: assert property (call_req |->
		!$past(in_service[1]))
		else $error("high handler preempted");
	a_exit_only: assert property (!call_req &&
		!$past(handler_exit) |-> $stable(in_service))
		else $error("level changed without exit");
	a_exit_high: assert property (handler_exit &&
		in_service[1] |=> !in_service[1] &&
		in_service[0] == $past(in_service[0]))
		else $error("exit did not clear high first");
	a_no_status: assert property (!call_save_psw)
		else $error("status word saved");
	a_mc_period: assert property (mc_strobe |=>
		!mc_strobe[*3] ##1 mc_strobe)
		else $error("machine cycle not four clocks");
endmodule
bind tlv_irq_ctrl tlv_irq_chk u_chk (
	.hclk(hclk), .hresetn(hresetn), .instr_last(instr_last),
	.instr_blocks(instr_blocks), .handler_exit(handler_exit),
	.mc_strobe(mc_strobe), .call_req(call_req),
	.call_vector(call_vector), .call_save_psw(call_save_psw),
	.call_busy(call_busy), .in_service(in_service));
`default_nettype wire

/* File: testbench/tlv_core_mdl.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Core side: instruction boundaries and handler exit
module tlv_core_mdl (
	input  wire logic hclk,         // Clock
	input  wire logic hresetn,      // Reset, low
	input  wire logic mc_strobe,    // Poll clock
	input  wire logic call_busy,    // Call runs
	input  wire logic slow,         // Two-mc instructions
	input  wire logic blk,          // Ctl-reg write op
	input  wire logic ret_cmd,      // Run handler exit
	output var  logic instr_last,   // Last mc
	output var  logic instr_blocks, // Blocking op
	output var  logic handler_exit  // Exit pulse
);
	logic mc_odd; // Odd machine cycle
	// Exit is dropped while a call runs; a core cannot exit mid-call
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mc_odd       <= 1'b0;
			handler_exit <= 1'b0;
		end else begin
			if (mc_strobe) begin
				mc_odd <= ~mc_odd;
			end
			handler_exit <= ret_cmd & ~call_busy;
		end
	end
	// Slow mode ends an instruction every second machine cycle
	assign instr_last   = ~slow | mc_odd;
	// The exit instruction itself blocks a call
	assign instr_blocks = blk | handler_exit;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        hclk, hresetn, hsel, hwrite, hrdy, hresp;
	logic        x0, x1, x2, x3, pwm, slow, blk, ret_cmd;
	logic        last, blks, hexit, mcs, creq, csave, cbusy;
	logic        cidle;
	logic [1:0]  htrans, isv;
	logic [2:0]  hsize;
	logic [6:0]  pls;
	logic [10:0] rem;
	logic [15:0] cvec;
	logic [31:0] haddr, hwdata, hrdata, r;
	int          error_cnt, checks_done;
	logic [15:0] vec [10] = '{16'h0003, 16'h000B, 16'h0013,
		16'h001B, 16'h0023, 16'h003B, 16'h0043, 16'h004B,
		16'h0063, 16'h006B};
	tlv_irq_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hrdy),
		.hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
		.ext_irq0_n(x0), .ext_irq1_n(x1), .ext_irq2_rise(x2),
		.ext_irq3_n(x3), .timer0_ovf(pls[0]), .timer1_ovf(pls[1]),
		.uart_rx_done(pls[2]), .uart_tx_done(pls[3]),
		.conv_done(pls[4]), .conv_start(pls[5]),
		.wdog_timeout(pls[6]), .pwm_out(pwm), .instr_last(last),
		.instr_blocks(blks), .handler_exit(hexit),
		.mc_strobe(mcs), .call_req(creq), .call_vector(cvec),
		.call_save_psw(csave), .call_busy(cbusy),
		.in_service(isv), .conv_idle(cidle));
	tlv_core_mdl u_core (.hclk(hclk), .hresetn(hresetn),
		.mc_strobe(mcs), .call_busy(cbusy), .slow(slow),
		.blk(blk), .ret_cmd(ret_cmd), .instr_last(last),
		.instr_blocks(blks), .handler_exit(hexit));
	always #50 hclk = ~hclk;
	////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic hang;
		error_cnt++;
		$display("unexpected at %0t: wait ran out", $time);
		final_report;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Waits for hready; a stuck bus ends the run
	task automatic wrdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hrdy !== 1'b1 && k < 20);
		if (hrdy !== 1'b1) hang;
	endtask
	// Single word transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		hsize  <= 3'h2;
		wrdy;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wrdy;
		r = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(r, e);
	endtask
	task automatic pulse(input int i);
		pls <= 7'h01 << i;
		@(posedge hclk);
		pls <= 7'h00;
		@(posedge hclk);
	endtask
	task automatic wcall(input logic [15:0] v);
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (creq !== 1'b1 && k < 200);
		if (creq !== 1'b1) hang;
		chk({16'h0, cvec}, {16'h0, v});
		chk({31'h0, csave}, 32'h0);
	endtask
	task automatic nocall(input int n);
		int s;
		s = 0;
		repeat (n) begin
			@(posedge hclk);
			if (creq !== 1'b0) s++;
		end
		chk(s, 0);
	endtask
	// Handler exit, issued once the call has finished
	task automatic ret;
		int k;
		k = 0;
		while (cbusy !== 1'b0 && k < 40) begin
			@(posedge hclk);
			k++;
		end
		if (cbusy !== 1'b0) hang;
		ret_cmd <= 1'b1;
		@(posedge hclk);
		ret_cmd <= 1'b0;
		tick(2);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0;
		hwrite = 0; hsize = 0; hwdata = 0; pls = 0; pwm = 0;
		x0 = 1; x1 = 1; x2 = 0; x3 = 1; slow = 0; blk = 0;
		ret_cmd = 0; error_cnt = 0; checks_done = 0;
		tick(10);
		hresetn <= 1'b1;
		tick(9);
		// Reset values
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h0C, 32'h0);
		rd(8'h10, 32'hF8);
		rd(8'h20, 32'h0);
		// All flags set by software, served in fixed order
		wr_all: begin
			ahb(1'b1, 8'h00, 32'h6);
			ahb(1'b1, 8'h04, 32'h3FF);
			ahb(1'b1, 8'h0C, 32'h7FF);
			rd(8'h0C, 32'h7FF);
			nocall(8);
			ahb(1'b1, 8'h00, 32'h7);
		end
		rem = 11'h7FF;
		for (int i = 0; i < 10; i++) begin
			wcall(vec[i]);
			if (i < 4) rem[i] = 1'b0;
			rd(8'h0C, {21'h0, rem});
			rem[i] = 1'b0;
			if (i == 4) rem[10] = 1'b0;
			ahb(1'b1, 8'h0C, {21'h0, rem});
			ret;
		end
		chk({30'h0, isv}, 32'h0);
		// Blocked poll is not remembered
		blk <= 1'b1;
		pulse(0);
		nocall(16);
		ahb(1'b1, 8'h0C, 32'h0);
		blk <= 1'b0;
		nocall(16);
		// Source mask
		ahb(1'b1, 8'h04, 32'h3FD);
		pulse(0);
		nocall(12);
		rd(8'h0C, 32'h2);
		ahb(1'b1, 8'h04, 32'h3FF);
		wcall(16'h000B);
		rd(8'h0C, 32'h0);
		ret;
		// Two levels: timer 1 high
		slow <= 1'b1;
		ahb(1'b1, 8'h08, 32'h8);
		pulse(0);
		wcall(16'h000B);
		pulse(1);
		wcall(16'h001B);
		chk({30'h0, isv}, 32'h3);
		pulse(0);
		nocall(24);
		ret;
		chk({30'h0, isv}, 32'h1);
		nocall(12);
		ret;
		wcall(16'h000B);
		tick(40);
		chk({30'h0, isv}, 32'h1);
		ret;
		chk({30'h0, isv}, 32'h0);
		slow <= 1'b0;
		ahb(1'b1, 8'h08, 32'h0);
		// Edges and flag sources with the gate off
		ahb(1'b1, 8'h00, 32'h6);
		pulse(5);
		tick(2);
		ahb(1'b0, 8'h10, 32'h0);
		chk(r & 32'h8, 32'h0);
		x0 <= 1'b0; x2 <= 1'b1; x3 <= 1'b0; pwm <= 1'b1;
		pulse(6);
		pulse(4);
		pulse(2);
		tick(12);
		rd(8'h0C, 32'h3F1);
		ahb(1'b0, 8'h10, 32'h0);
		chk(r & 32'h8, 32'h8);
		chk({31'h0, cidle}, 32'h1);
		chk({31'h0, hresp}, 32'h0);
		x0 <= 1'b1; x2 <= 1'b0; x3 <= 1'b1; pwm <= 1'b0;
		ahb(1'b1, 8'h0C, 32'h0);
		tick(12);
		rd(8'h0C, 32'h0);
		ahb(1'b1, 8'h04, 32'h1FF);
		pwm <= 1'b1;
		tick(8);
		rd(8'h0C, 32'h0);
		// Level mode on request 0, pin held low until served
		ahb(1'b1, 8'h00, 32'h1);
		x0 <= 1'b0;
		wcall(16'h0003);
		rd(8'h0C, 32'h1);
		ret;
		wcall(16'h0003);
		x0 <= 1'b1;
		ret;
		tick(8);
		rd(8'h0C, 32'h0);
		pulse(3);
		wcall(16'h0023);
		rd(8'h0C, 32'h400);
		ahb(1'b1, 8'h0C, 32'h0);
		ret;
		final_report;
	end
endmodule
`default_nettype wire
